// ===== logic/pst_ctl_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pst_ctl_if;
    logic [7:0] pending;
    logic ack;
    logic eos;
    logic [2:0] eos_level;
    logic [7:0] in_service;
    logic int_out;
    logic [2:0] top_level;
    logic eos_idle;
    modport ctrl (
        input pending, ack, eos, eos_level,
        output in_service, int_out, top_level, eos_idle
    );
    modport host (
        output pending, ack, eos, eos_level,
        input in_service, int_out, top_level, eos_idle
    );
endinterface
`default_nettype wire

// ===== logic/pst_pkg.sv
`default_nettype none
package pst_pkg;
    localparam int NUM_LEVELS = 16;
    localparam int CTRL_WIDTH = 8;
    localparam int ADDR_WIDTH = 4;
    // address: region in the upper two bits, offset in the lower two
    localparam logic [1:0] RGN_PRIMARY = 2'h0;
    localparam logic [1:0] RGN_SECONDARY = 2'h1;
    localparam logic [1:0] RGN_TRIGGER = 2'h2;
    localparam logic [1:0] RGN_CONTROL = 2'h3;
    localparam logic [1:0] OFS_COMMAND = 2'h0;
    localparam logic [1:0] OFS_TRIG_PRIMARY = 2'h0;
    localparam logic [1:0] OFS_TRIG_SECONDARY = 2'h1;
    localparam logic [1:0] OFS_ACK = 2'h0;
    localparam logic [1:0] OFS_EOS = 2'h1;
    localparam logic [1:0] OFS_STATUS = 2'h2;
    localparam logic [1:0] OFS_MASK = 2'h3;
    // command word layout
    localparam int CW_SELECT_LSB = 3;
    localparam logic [1:0] CW_SELECT_THIRD = 2'h1;
    localparam int CW_READ_LSB = 0;
    localparam logic [1:0] RD_CMD_PENDING = 2'h2;
    localparam logic [1:0] RD_CMD_IN_SERVICE = 2'h3;
    // trigger-mode bytes: writable bits, others read zero
    localparam logic [7:0] TRIG_PRIMARY_WMASK = 8'hF8;
    localparam logic [7:0] TRIG_SECONDARY_WMASK = 8'hDE;
    localparam logic [7:0] TRIG_RESET = 8'h00;
    localparam logic [2:0] CASCADE_LEVEL = 3'h2;
    localparam int EOS_LEVEL_LSB = 0;
    localparam int VECTOR_VALID_BIT = 7;
    localparam logic [7:0] VECTOR_RESET = 8'h00;
    // interrupt status bits
    localparam int ST_DELIVER = 0;
    localparam int ST_SPURIOUS_ACK = 1;
    localparam int ST_EOS_IDLE = 2;
    localparam int ST_CASCADE_ACK = 3;
    localparam logic [7:0] STATUS_WMASK = 8'h0F;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    typedef enum logic [1:0] {
        PST_SEL_PENDING = 2'b01,
        PST_SEL_IN_SERVICE = 2'b10
    } pst_rd_sel_t;
    // {found, index} of the lowest set bit, i.e. the highest priority
    function automatic logic [3:0] pst_first_set(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction
    function automatic logic pst_hit(input logic [3:0] a,
        input logic [1:0] rgn, input logic [1:0] ofs);
        return a == {rgn, ofs};
    endfunction
endpackage
`default_nettype wire

// ===== logic/pst_service.sv
`timescale 1ns/100ps
`default_nettype none
module pst_service (
    input wire logic core_clk, // system clock
    input wire logic rst, // synchronous reset, active high
    pst_ctl_if.ctrl c // one controller's request and service signals
);
    logic [7:0] in_service_r;
    logic [3:0] hi_service;
    logic [3:0] hi_deliver;
    logic [7:0] deliver;

    assign hi_service = pst_pkg::pst_first_set(in_service_r);

    // bit 0 is the highest priority of its controller
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            deliver[i] = c.pending[i]
                && (!hi_service[3] || i < int'(hi_service[2:0]));
        end
    end

    assign hi_deliver = pst_pkg::pst_first_set(deliver);
    assign c.int_out = hi_deliver[3];
    assign c.top_level = hi_deliver[2:0];
    assign c.in_service = in_service_r;
    assign c.eos_idle = c.eos && !in_service_r[c.eos_level];

    // an acknowledge in the same cycle as an end-of-service wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            in_service_r <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (c.ack && hi_deliver[3] && hi_deliver[2:0] == 3'(i)) begin
                    in_service_r[i] <= 1'b1;
                end else if (c.eos && c.eos_level == 3'(i)) begin
                    in_service_r[i] <= 1'b0;
                end
            end
        end
    end
endmodule // pst_service
`default_nettype wire

// ===== logic/pst_top.sv
// Operation
// - pending byte records every edge-mode request not yet acknowledged; level-mode bits follow the request line
// - pending bit is one while a request waits, else zero
// - primary bit n is level n; secondary bit n is level n+8
// - pending byte is read-only, read at command offset after selection
// - in-service bit set on acknowledge, held until end-of-service
// - while in service, equal or lower priority requests are not delivered
// - higher priority requests are still delivered, allowing nesting
// - in-service byte is read-only, read at command offset after selection
// - trigger-mode bit zero means edge, one means level
// - reset puts every input into rising-edge mode
// - primary trigger bits 7 to 3 select mode of levels 7 to 3
// - primary trigger bits 2 to 0 read zero; levels 2-0 edge
// - secondary trigger bits 7,6,4,3,2,1 select levels 15,14,12,11,10,9
// - secondary trigger bits 5 and 0 read zero; levels 13, 8 edge
// - trigger bytes directly addressed, read/write, primary 0, secondary 1
// - read selection 2 returns pending byte, 3 returns in-service byte
// - selection holds for every later read until changed
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module pst_top (
    input wire logic core_clk, // system clock, 125 MHz
    input wire logic rst, // synchronous reset, active high
    input wire logic [3:0] addr, // register address
    input wire logic [7:0] wr_data, // register write data
    input wire logic wr_en, // write strobe
    input wire logic rd_en, // read strobe
    output logic [7:0] rd_data, // read data, cycle after rd_en
    input wire logic [15:0] req, // interrupt request inputs
    output logic cpu_int, // interrupt toward the processor
    output logic irq // status interrupt, level
);
    // trigger-mode bytes
    logic [7:0] trig_pri_r;
    logic [7:0] trig_sec_r;
    logic [15:0] trig_mode;

    // request sampling and pending state
    logic [15:0] req_d_r;
    logic [15:0] pending_r;
    logic [15:0] pend_clear;

    // read selection per controller
    pst_pkg::pst_rd_sel_t sel_pri_r;
    pst_pkg::pst_rd_sel_t sel_sec_r;

    // acknowledge and end-of-service
    logic ack_wr;
    logic eos_wr;
    logic cascade_hit;
    logic [7:0] vector_r;
    logic [7:0] vector_nxt;
    logic [3:0] eos_level;

    // interrupt status
    logic [7:0] status_r;
    logic [7:0] mask_r;
    logic [7:0] events;
    logic cpu_int_r;
    logic irq_r;

    // read path
    logic [7:0] rd_data_r;
    logic [7:0] rd_mux;
    logic [7:0] pri_pend_view;

    // register decode
    logic wr_cmd_pri;
    logic wr_cmd_sec;
    logic wr_trig_pri;
    logic wr_trig_sec;
    logic wr_status;
    logic wr_mask;
    logic cw_third;
    logic cw_read_cmd;
    pst_pkg::pst_rd_sel_t cw_sel;

    pst_ctl_if pri_if ();
    pst_ctl_if sec_if ();

    pst_service u_primary (
        .core_clk(core_clk),
        .rst(rst),
        .c(pri_if.ctrl)
    );

    pst_service u_secondary (
        .core_clk(core_clk),
        .rst(rst),
        .c(sec_if.ctrl)
    );

    assign wr_cmd_pri = wr_en && pst_pkg::pst_hit(addr,
        pst_pkg::RGN_PRIMARY, pst_pkg::OFS_COMMAND);
    assign wr_cmd_sec = wr_en && pst_pkg::pst_hit(addr,
        pst_pkg::RGN_SECONDARY, pst_pkg::OFS_COMMAND);
    assign wr_trig_pri = wr_en && pst_pkg::pst_hit(addr,
        pst_pkg::RGN_TRIGGER, pst_pkg::OFS_TRIG_PRIMARY);
    assign wr_trig_sec = wr_en && pst_pkg::pst_hit(addr,
        pst_pkg::RGN_TRIGGER, pst_pkg::OFS_TRIG_SECONDARY);
    assign ack_wr = wr_en && pst_pkg::pst_hit(addr,
        pst_pkg::RGN_CONTROL, pst_pkg::OFS_ACK);
    assign eos_wr = wr_en && pst_pkg::pst_hit(addr,
        pst_pkg::RGN_CONTROL, pst_pkg::OFS_EOS);
    assign wr_status = wr_en && pst_pkg::pst_hit(addr,
        pst_pkg::RGN_CONTROL, pst_pkg::OFS_STATUS);
    assign wr_mask = wr_en && pst_pkg::pst_hit(addr,
        pst_pkg::RGN_CONTROL, pst_pkg::OFS_MASK);

    // only the third command word with a read command changes selection
    assign cw_third = wr_data[pst_pkg::CW_SELECT_LSB +: 2]
        == pst_pkg::CW_SELECT_THIRD;
    assign cw_read_cmd = wr_data[pst_pkg::CW_READ_LSB +: 2]
        == pst_pkg::RD_CMD_PENDING
        || wr_data[pst_pkg::CW_READ_LSB +: 2]
        == pst_pkg::RD_CMD_IN_SERVICE;
    assign cw_sel = (wr_data[pst_pkg::CW_READ_LSB +: 2]
        == pst_pkg::RD_CMD_IN_SERVICE)
        ? pst_pkg::PST_SEL_IN_SERVICE : pst_pkg::PST_SEL_PENDING;

    // trigger-mode bytes; fixed-edge bits never store a one
    always_ff @(posedge core_clk) begin
        if (rst) begin
            trig_pri_r <= pst_pkg::TRIG_RESET;
        end else if (wr_trig_pri) begin
            trig_pri_r <= wr_data & pst_pkg::TRIG_PRIMARY_WMASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            trig_sec_r <= pst_pkg::TRIG_RESET;
        end else if (wr_trig_sec) begin
            trig_sec_r <= wr_data & pst_pkg::TRIG_SECONDARY_WMASK;
        end
    end

    assign trig_mode = {trig_sec_r, trig_pri_r};

    // previous request level for rising-edge detection
    always_ff @(posedge core_clk) begin
        if (rst) begin
            req_d_r <= 16'h0000;
        end else begin
            req_d_r <= req;
        end
    end

    // a cascade acknowledge is taken by the secondary, not external level 2
    always_comb begin
        pend_clear = 16'h0000;
        if (ack_wr && pri_if.int_out && !cascade_hit) begin
            pend_clear[{1'b0, pri_if.top_level}] = 1'b1;
        end
        if (ack_wr && cascade_hit) begin
            pend_clear[{1'b1, sec_if.top_level}] = 1'b1;
        end
    end

    // rising edge set wins over an acknowledge clear in the same cycle
    for (genvar i = 0; i < pst_pkg::NUM_LEVELS; i++) begin : g_pend
        always_ff @(posedge core_clk) begin
            if (rst) begin
                pending_r[i] <= 1'b0;
            end else if (trig_mode[i]) begin
                pending_r[i] <= req[i];
            end else if (req[i] && !req_d_r[i]) begin
                pending_r[i] <= 1'b1;
            end else if (pend_clear[i]) begin
                pending_r[i] <= 1'b0;
            end
        end
    end

    // secondary request enters the primary at the cascade level
    always_comb begin
        pri_pend_view = pending_r[7:0];
        pri_pend_view[pst_pkg::CASCADE_LEVEL] =
            pending_r[pst_pkg::CASCADE_LEVEL] | sec_if.int_out;
    end

    assign cascade_hit = pri_if.int_out && sec_if.int_out
        && pri_if.top_level == pst_pkg::CASCADE_LEVEL;

    assign pri_if.pending = pri_pend_view;
    assign sec_if.pending = pending_r[15:8];
    assign pri_if.ack = ack_wr;
    assign sec_if.ack = ack_wr && cascade_hit;

    // end-of-service write carries the level 0 to 15
    assign eos_level = wr_data[pst_pkg::EOS_LEVEL_LSB +: 4];
    assign pri_if.eos = eos_wr && !eos_level[3];
    assign sec_if.eos = eos_wr && eos_level[3];
    assign pri_if.eos_level = eos_level[2:0];
    assign sec_if.eos_level = eos_level[2:0];

    // acknowledge vector: valid bit and the level that went into service
    always_comb begin
        vector_nxt = 8'h00;
        if (cascade_hit) begin
            vector_nxt[pst_pkg::VECTOR_VALID_BIT] = 1'b1;
            vector_nxt[3:0] = {1'b1, sec_if.top_level};
        end else if (pri_if.int_out) begin
            vector_nxt[pst_pkg::VECTOR_VALID_BIT] = 1'b1;
            vector_nxt[3:0] = {1'b0, pri_if.top_level};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            vector_r <= pst_pkg::VECTOR_RESET;
        end else if (ack_wr) begin
            vector_r <= vector_nxt;
        end
    end

    // selection persists across reads, only a new command changes it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sel_pri_r <= pst_pkg::PST_SEL_PENDING;
        end else if (wr_cmd_pri && cw_third && cw_read_cmd) begin
            sel_pri_r <= cw_sel;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sel_sec_r <= pst_pkg::PST_SEL_PENDING;
        end else if (wr_cmd_sec && cw_third && cw_read_cmd) begin
            sel_sec_r <= cw_sel;
        end
    end

    // status events
    always_comb begin
        events = 8'h00;
        events[pst_pkg::ST_DELIVER] = pri_if.int_out && !cpu_int_r;
        events[pst_pkg::ST_SPURIOUS_ACK] = ack_wr && !pri_if.int_out;
        events[pst_pkg::ST_EOS_IDLE] = pri_if.eos_idle || sec_if.eos_idle;
        events[pst_pkg::ST_CASCADE_ACK] = ack_wr && cascade_hit;
    end

    // a new event beats a write-one-to-clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            status_r <= pst_pkg::STATUS_RESET;
        end else if (wr_status) begin
            status_r <= (status_r & ~(wr_data & pst_pkg::STATUS_WMASK))
                | events;
        end else begin
            status_r <= status_r | events;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mask_r <= pst_pkg::MASK_RESET;
        end else if (wr_mask) begin
            mask_r <= wr_data & pst_pkg::STATUS_WMASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_r & mask_r);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cpu_int_r <= 1'b0;
        end else begin
            cpu_int_r <= pri_if.int_out;
        end
    end

    // read multiplexer; unmapped offsets read zero
    always_comb begin
        rd_mux = 8'h00;
        unique case (addr[3:2])
            pst_pkg::RGN_PRIMARY: begin
                if (addr[1:0] == pst_pkg::OFS_COMMAND) begin
                    rd_mux = (sel_pri_r == pst_pkg::PST_SEL_IN_SERVICE)
                        ? pri_if.in_service : pri_pend_view;
                end
            end
            pst_pkg::RGN_SECONDARY: begin
                if (addr[1:0] == pst_pkg::OFS_COMMAND) begin
                    rd_mux = (sel_sec_r == pst_pkg::PST_SEL_IN_SERVICE)
                        ? sec_if.in_service : pending_r[15:8];
                end
            end
            pst_pkg::RGN_TRIGGER: begin
                if (addr[1:0] == pst_pkg::OFS_TRIG_PRIMARY) begin
                    rd_mux = trig_pri_r;
                end else if (addr[1:0] == pst_pkg::OFS_TRIG_SECONDARY) begin
                    rd_mux = trig_sec_r;
                end
            end
            pst_pkg::RGN_CONTROL: begin
                unique case (addr[1:0])
                    pst_pkg::OFS_ACK: rd_mux = vector_r;
                    pst_pkg::OFS_EOS: rd_mux = 8'h00;
                    pst_pkg::OFS_STATUS: rd_mux = status_r;
                    pst_pkg::OFS_MASK: rd_mux = mask_r;
                endcase
            end
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_data_r <= 8'h00;
        end else if (rd_en) begin
            rd_data_r <= rd_mux;
        end else begin
            rd_data_r <= 8'h00;
        end
    end

    assign rd_data = rd_data_r;
    assign cpu_int = cpu_int_r;
    assign irq = irq_r;
endmodule // pst_top
`default_nettype wire

// ===== sim/pst_req_src.sv
`timescale 1ns/100ps
`default_nettype none
module pst_req_src (
    input wire logic core_clk, // system clock
    input wire logic rst, // reset, lines go low
    input wire logic [15:0] lvl, // wanted request levels
    output logic [15:0] req // request lines to the controller
);
    // registered so the lines move just after an edge, like real sources
    always_ff @(posedge core_clk) begin
        if (rst) begin
            req <= 16'h0000;
        end else begin
            req <= lvl;
        end
    end
endmodule // pst_req_src
`default_nettype wire

// ===== sim/pst_top_chk.sv
`timescale 1ns/100ps
`default_nettype none
module pst_top_chk (
    input wire logic core_clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic [3:0] addr, // register address
    input wire logic [7:0] wr_data, // write data
    input wire logic wr_en, // write strobe
    input wire logic rd_en, // read strobe
    input wire logic [7:0] rd_data, // read data
    input wire logic [15:0] req, // request inputs
    input wire logic cpu_int, // processor interrupt
    input wire logic irq // status interrupt
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_rd_idle_zero: assert property (
        !$past(rd_en) |-> rd_data == 8'h00)
        else $error("read data not zero outside a read");
    a_trig_p_rsvd: assert property (
        $past(rd_en) && $past(addr) == 4'h8 |-> rd_data[2:0] == 3'h0)
        else $error("primary trigger low bits not zero");
    a_trig_s_rsvd: assert property (
        $past(rd_en) && $past(addr) == 4'h9
        |-> rd_data[5] == 1'b0 && rd_data[0] == 1'b0)
        else $error("secondary trigger reserved bits not zero");
    a_trig_p_back: assert property (
        (wr_en && addr == 4'h8) ##1 !wr_en ##1 (rd_en && addr == 4'h8)
        |=> rd_data == ($past(wr_data, 3) & 8'hF8))
        else $error("primary trigger readback wrong");
    a_trig_s_back: assert property (
        (wr_en && addr == 4'h9) ##1 !wr_en ##1 (rd_en && addr == 4'h9)
        |=> rd_data == ($past(wr_data, 3) & 8'hDE))
        else $error("secondary trigger readback wrong");
    a_reset_quiet: assert property (
        $fell(rst) |-> !cpu_int && !irq && rd_data == 8'h00)
        else $error("outputs not quiet after reset");
    a_unmapped_zero: assert property (
        $past(rd_en) && $past(addr[1:0]) != 2'h0 && !$past(addr[3])
        |-> rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_irq_masked: assert property (
        (wr_en && addr == 4'hF && wr_data[3:0] == 4'h0)
        ##1 !(wr_en && addr == 4'hF) |=> !irq)
        else $error("status interrupt high with mask clear");
endmodule // pst_top_chk
bind pst_top pst_top_chk u_chk (.core_clk(core_clk), .rst(rst),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .req(req), .cpu_int(cpu_int), .irq(irq));
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic core_clk;
    logic rst;
    logic [3:0] addr;
    logic [7:0] wr_data;
    logic wr_en;
    logic rd_en;
    logic [7:0] rd_data;
    logic [15:0] req;
    logic [15:0] lvl;
    logic cpu_int;
    logic irq;
    logic [7:0] v;
    int miscompares;
    int num_checks;

    pst_top dut (.core_clk(core_clk), .rst(rst), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .req(req), .cpu_int(cpu_int), .irq(irq));
    pst_req_src src (.core_clk(core_clk), .rst(rst), .lvl(lvl),
        .req(req));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic set_req(input logic [15:0] l);
        @(posedge core_clk);
        lvl <= l;
    endtask

    // bounded wait; a hang ends the run with the report
    task automatic wait_int(input logic e);
        int n;
        n = 0;
        while (cpu_int !== e && n < 8) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        num_checks++;
        if (cpu_int !== e) begin
            miscompares++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, cpu_int, e);
            give_verdict();
        end
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        rst <= 1'b1;
        lvl <= 16'h0000;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
    endtask

    task automatic t_reset();
        rdchk(4'h8, 8'h00);
        rdchk(4'h9, 8'h00);
        rdchk(4'h0, 8'h00);
        rdchk(4'h4, 8'h00);
        wr(4'h1, 8'hFF);
        rdchk(4'h1, 8'h00);
        wr(4'h0, 8'h0B);
        rdchk(4'h0, 8'h00);
    endtask

    task automatic t_trig();
        wr(4'h8, 8'hFF);
        rdchk(4'h8, 8'hF8);
        wr(4'h9, 8'hFF);
        rdchk(4'h9, 8'hDE);
        wr(4'h8, 8'h50);
        rdchk(4'h8, 8'h50);
        wr(4'h9, 8'h21);
        rdchk(4'h9, 8'h00);
    endtask

    // level 3 level-mode, level 2 stuck at edge even with its bit written
    task automatic t_level();
        wr(4'h0, 8'h0A);
        wr(4'h8, 8'hFF);
        set_req(16'h000C);
        cyc(3);
        rdchk(4'h0, 8'h0C);
        set_req(16'h0000);
        cyc(3);
        rdchk(4'h0, 8'h04);
        wr(4'h8, 8'h00);
        set_req(16'h0008);
        cyc(3);
        set_req(16'h0000);
        cyc(3);
        rdchk(4'h0, 8'h0C);
        wr(4'h9, 8'hFF);
        set_req(16'h2200);
        cyc(3);
        set_req(16'h0000);
        cyc(3);
        rdchk(4'h4, 8'h20);
    endtask

    task automatic t_nest();
        set_req(16'h0020);
        wait_int(1'b1);
        rdchk(4'h0, 8'h20);
        wr(4'hC, 8'h00);
        rdchk(4'hC, 8'h85);
        wait_int(1'b0);
        wr(4'h0, 8'h0B);
        rdchk(4'h0, 8'h20);
        rdchk(4'h0, 8'h20);
        // other command words and no-action reads keep the selection
        wr(4'h0, 8'h02);
        wr(4'h0, 8'h09);
        rdchk(4'h0, 8'h20);
        set_req(16'h0000);
        set_req(16'h0060);
        cyc(4);
        chk({7'h00, cpu_int}, 8'h00);
        wr(4'h0, 8'h0A);
        rdchk(4'h0, 8'h60);
        set_req(16'h0068);
        wait_int(1'b1);
        wr(4'hC, 8'h00);
        rdchk(4'hC, 8'h83);
        wr(4'h0, 8'h0B);
        rdchk(4'h0, 8'h28);
        wr(4'hD, 8'h03);
        wr(4'hD, 8'h05);
        rdchk(4'h0, 8'h00);
        wait_int(1'b1);
    endtask

    task automatic t_cascade();
        set_req(16'h2000);
        wait_int(1'b1);
        rdchk(4'h4, 8'h20);
        rdchk(4'h0, 8'h04);
        wr(4'hC, 8'h00);
        rdchk(4'hC, 8'h8D);
        rdchk(4'hE, 8'h09);
        wr(4'h4, 8'h0B);
        rdchk(4'h4, 8'h20);
        // end-of-service to level 12, which is not in service
        wr(4'hD, 8'h0C);
        rdchk(4'hE, 8'h0D);
        wr(4'hE, 8'h0F);
        rdchk(4'hE, 8'h00);
    endtask

    // spurious acknowledge sets status bit 1 with nothing waiting
    task automatic t_irq();
        wr(4'hC, 8'h00);
        rd(4'hC, v);
        chk(v & 8'h80, 8'h00);
        rdchk(4'hE, 8'h02);
        wr(4'hF, 8'h02);
        cyc(2);
        chk({7'h00, irq}, 8'h01);
        wr(4'hF, 8'h00);
        cyc(2);
        chk({7'h00, irq}, 8'h00);
        wr(4'hF, 8'h02);
        wr(4'hE, 8'h02);
        cyc(2);
        chk({7'h00, irq}, 8'h00);
        rdchk(4'hE, 8'h00);
        rdchk(4'hF, 8'h02);
    endtask

    initial begin
        rst = 1'b1;
        addr = 4'h0;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        lvl = 16'h0000;
        miscompares = 0;
        num_checks = 0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_trig();
        do_reset();
        t_level();
        do_reset();
        t_nest();
        do_reset();
        t_cascade();
        do_reset();
        t_irq();
        give_verdict();
    end
endmodule // tb
`default_nettype wire
